// File: rtl/covr_consts.svh
/*
  Constants for the output current offset and overvoltage fault registers.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef COVR_CONSTS_SVH
`define COVR_CONSTS_SVH

`define COVR_CMD_IOUT_OFS 8'h39
`define COVR_CMD_OV_LIMIT 8'h40
`define COVR_CMD_OV_RESP 8'h41

`define COVR_OFS_EXPONENT 5'h1e
`define COVR_OFS_MANT_SIGN 3
`define COVR_RESP_EN_N_BIT 7
`define COVR_RETRY_MSB 5
`define COVR_RETRY_LSB 3
`define COVR_RETRY_LATCH 3'h0
`define COVR_RETRY_AUTO 3'h7

`define COVR_RST_MANT 4'h0
`define COVR_RST_LIMIT 11'h000
`define COVR_RST_RESP_EN_N 1'b1
`define COVR_RST_RETRY 1'b0

`define COVR_BRK_16 11'h248
`define COVR_BRK_20 11'h25c
`define COVR_BRK_50 11'h29a
`define COVR_PCT_12 8'h0c
`define COVR_PCT_16 8'h10
`define COVR_PCT_20 8'h14
`define COVR_PCT_50 8'h32
`define COVR_PCT_BASE 8'h64

`define COVR_RETRY_DELAY_MS 52
`define COVR_SYS_CLK_KHZ 125000

`endif

// File: rtl/covr_pkg.sv
/*
  Types shared by the overvoltage fault register block.
  Assumes the constants header is compiled alongside.
*/
package covr_pkg;

  typedef enum logic [2:0] {
    COVR_ST_RUN = 3'b001,
    COVR_ST_LATCHED = 3'b010,
    COVR_ST_RETRY = 3'b100
  } covr_state_t;

endpackage

// File: rtl/covr_sync2.sv
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes the input is a slowly changing level.
*/
`timescale 1ns/1ps
module covr_sync2 (
  input wire logic clk, // Destination clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic d, // Asynchronous level.
  output logic q // Synchronised level.
);

  logic meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// File: rtl/covr_ov_threshold.sv
/*
  Tracking overvoltage threshold: the commanded output voltage raised by
  the margin that the limit code selects.
  Assumes the commanded voltage and the sensed voltage share one scale.
*/
`timescale 1ns/1ps
`include "covr_consts.svh"
module covr_ov_threshold (
  input wire logic [10:0] limit, // Stored threshold code.
  input wire logic [15:0] vout_cmd, // Commanded output voltage.
  output logic [16:0] threshold // Trip level on the sensed scale.
);

  function automatic logic [7:0] margin_pct(input logic [10:0] code);
    if (code < `COVR_BRK_16) begin
      margin_pct = `COVR_PCT_12;
    end else if (code < `COVR_BRK_20) begin
      margin_pct = `COVR_PCT_16;
    end else if (code < `COVR_BRK_50) begin
      margin_pct = `COVR_PCT_20;
    end else begin
      margin_pct = `COVR_PCT_50;
    end
  endfunction

  logic [8:0] scale;
  logic [24:0] product;
  logic [24:0] quotient;

  always_comb begin
    scale = {1'b0, `COVR_PCT_BASE} + {1'b0, margin_pct(limit)};
    product = {9'h000, vout_cmd} * {16'h0000, scale};
    quotient = product / 25'(`COVR_PCT_BASE);
    threshold = quotient[16:0];
  end

endmodule

// File: rtl/covr_fault_regs.sv
/*
  Command registers for the output current calibration offset, the output
  overvoltage fault threshold and the overvoltage fault action, with the
  corrected current report, overvoltage detection and response sequencing.
  Assumes command, NVM, telemetry and configuration inputs run on SYS_CLK;
  EN_PIN and FIXED_OV_TRIP arrive asynchronously from pins.
*/
// Functional notes
// - Add signed offset to measured current.
// - Negative corrected current reports zero.
// - Offset exponent fixed read-only minus two.
// - Bits 10..4 copy mantissa sign bit.
// - Mantissa is four-bit two's complement.
// - Fault when sense exceeds command plus margin.
// - Tracking detection only after soft-start.
// - Eleven-bit threshold, upper bits read zero.
// - Threshold code selects 12/16/20/50 percent.
// - Fault sets three status flags, alert.
// - Response covers fixed threshold faults too.
// - Enable bit one: shut down, retry.
// - Enabling acts on uncleared earlier fault.
// - Response bit 6 reads zero.
// - Retry 000b latches off until EN toggle.
// - Retry 111b restarts after 52 ms forever.
// - Other retry codes rejected as invalid.
// - Delay field mirrors retry, read-only.
// - Invalid data sets flag and alerts.
`timescale 1ns/1ps
`include "covr_consts.svh"
module covr_fault_regs #(
  parameter logic [22:0] RETRY_CYCLES =
    23'(`COVR_RETRY_DELAY_MS * `COVR_SYS_CLK_KHZ)
) (
  input wire logic SYS_CLK, // System clock, 125 MHz.
  input wire logic ARST_N, // Asynchronous reset, active low.
  input wire logic CMD_VALID, // Command access strobe.
  input wire logic CMD_WRITE, // High for write, low for read.
  input wire logic [7:0] CMD_CODE, // Command code.
  input wire logic [15:0] CMD_WDATA, // Write data.
  output logic [15:0] CMD_RDATA, // Read data.
  output logic CMD_RVALID, // Read data valid pulse.
  output logic INVALID_DATA, // Sticky invalid data flag.
  input wire logic CLEAR_FAULTS, // Clear all fault flags pulse.
  input wire logic NVM_RESTORE, // Load stored values pulse.
  input wire logic [3:0] NVM_MANT, // Stored offset mantissa.
  input wire logic [10:0] NVM_LIMIT, // Stored threshold code.
  input wire logic NVM_RESP_EN_N, // Stored response enable bit.
  input wire logic NVM_RETRY, // Stored retry bit.
  output logic [3:0] STORE_MANT, // Mantissa image for NVM.
  output logic [10:0] STORE_LIMIT, // Threshold image for NVM.
  output logic STORE_RESP_EN_N, // Response enable image for NVM.
  output logic STORE_RETRY, // Single retry bit image for NVM.
  input wire logic [15:0] IOUT_MEAS, // Measured current, 0.25 A units.
  output logic [15:0] READ_IOUT, // Corrected current, 0.25 A units.
  input wire logic [15:0] VOUT_CMD, // Commanded output voltage.
  input wire logic [15:0] VOUT_SENSE, // Sensed differential voltage.
  input wire logic SOFTSTART_DONE, // Soft-start ramp finished.
  input wire logic FIXED_OV_SELECT, // Fixed threshold chosen.
  input wire logic FIXED_OV_TRIP, // Fixed comparator trip pin.
  input wire logic EN_PIN, // Enable pin.
  output logic CONVERT_EN, // Power conversion allowed.
  output logic RESTART, // Start a normal startup pulse.
  output logic STATUS_BYTE_OV, // Overvoltage flag, status byte.
  output logic STATUS_WORD_VOUT, // Output voltage flag, status word.
  output logic STATUS_VOUT_OV, // Overvoltage flag, output status.
  output logic SMBALERT_OUT, // Alert pin drive level.
  output logic SMBALERT_OE // Alert pin pulled low when high.
);

  function automatic logic retry_code_ok(input logic [2:0] code);
    retry_code_ok = (code == `COVR_RETRY_LATCH) ||
                    (code == `COVR_RETRY_AUTO);
  endfunction

  logic [3:0] mant;
  logic [10:0] limit;
  logic resp_en_n;
  logic retry_bit;
  logic invalid_flag;
  logic ov_flag;
  logic pending;
  logic ov_hit;
  logic en_s;
  logic en_d;
  logic en_rise;
  logic trip_s;
  logic retry_done;
  logic [22:0] retry_cnt;
  logic [16:0] threshold;
  logic [17:0] iout_sum;
  logic [2:0] retry_field;
  logic wr_ofs;
  logic wr_lim;
  logic wr_resp;
  logic act_fault;
  covr_pkg::covr_state_t state;
  covr_pkg::covr_state_t next_state;

  covr_sync2 u_en_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .d(EN_PIN),
    .q(en_s)
  );

  covr_sync2 u_trip_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .d(FIXED_OV_TRIP),
    .q(trip_s)
  );

  covr_ov_threshold u_threshold (
    .limit(limit),
    .vout_cmd(VOUT_CMD),
    .threshold(threshold)
  );

  // Write decode.
  always_comb begin
    wr_ofs = 1'b0;
    wr_lim = 1'b0;
    wr_resp = 1'b0;
    if (CMD_VALID && CMD_WRITE && CMD_CODE == `COVR_CMD_IOUT_OFS) begin
      wr_ofs = 1'b1;
    end else if (CMD_VALID && CMD_WRITE &&
                 CMD_CODE == `COVR_CMD_OV_LIMIT) begin
      wr_lim = 1'b1;
    end else if (CMD_VALID && CMD_WRITE &&
                 CMD_CODE == `COVR_CMD_OV_RESP) begin
      wr_resp = 1'b1;
    end
  end

  assign retry_field = CMD_WDATA[`COVR_RETRY_MSB:`COVR_RETRY_LSB];

  // NVM restore takes precedence over a host write in the same cycle.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mant <= `COVR_RST_MANT;
      limit <= `COVR_RST_LIMIT;
      resp_en_n <= `COVR_RST_RESP_EN_N;
      retry_bit <= `COVR_RST_RETRY;
    end else if (NVM_RESTORE) begin
      mant <= NVM_MANT;
      limit <= NVM_LIMIT;
      resp_en_n <= NVM_RESP_EN_N;
      retry_bit <= NVM_RETRY;
    end else begin
      if (wr_ofs) begin
        mant <= CMD_WDATA[3:0];
      end
      if (wr_lim) begin
        limit <= CMD_WDATA[10:0];
      end
      if (wr_resp && retry_code_ok(retry_field)) begin
        resp_en_n <= CMD_WDATA[`COVR_RESP_EN_N_BIT];
        retry_bit <= retry_field[2];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      invalid_flag <= 1'b0;
    end else if (wr_resp && !retry_code_ok(retry_field)) begin
      invalid_flag <= 1'b1;
    end else if (CLEAR_FAULTS) begin
      invalid_flag <= 1'b0;
    end
  end

  // Read path; unmapped codes return zero.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD_RDATA <= 16'h0000;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_VALID && !CMD_WRITE;
      if (CMD_VALID && !CMD_WRITE) begin
        if (CMD_CODE == `COVR_CMD_IOUT_OFS) begin
          CMD_RDATA <= {`COVR_OFS_EXPONENT,
                        {7{mant[`COVR_OFS_MANT_SIGN]}}, mant};
        end else if (CMD_CODE == `COVR_CMD_OV_LIMIT) begin
          CMD_RDATA <= {5'h00, limit};
        end else if (CMD_CODE == `COVR_CMD_OV_RESP) begin
          CMD_RDATA <= {8'h00, resp_en_n, 1'b0,
                        {3{retry_bit}}, {3{retry_bit}}};
        end else begin
          CMD_RDATA <= 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      STORE_MANT <= `COVR_RST_MANT;
      STORE_LIMIT <= `COVR_RST_LIMIT;
      STORE_RESP_EN_N <= `COVR_RST_RESP_EN_N;
      STORE_RETRY <= `COVR_RST_RETRY;
    end else begin
      STORE_MANT <= mant;
      STORE_LIMIT <= limit;
      STORE_RESP_EN_N <= resp_en_n;
      STORE_RETRY <= retry_bit;
    end
  end

  assign iout_sum = {2'b00, IOUT_MEAS} +
                    {{14{mant[`COVR_OFS_MANT_SIGN]}}, mant};

  // Overflow past full scale saturates rather than wrapping.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      READ_IOUT <= 16'h0000;
    end else if (iout_sum[17]) begin
      READ_IOUT <= 16'h0000;
    end else if (iout_sum[16]) begin
      READ_IOUT <= 16'hffff;
    end else begin
      READ_IOUT <= iout_sum[15:0];
    end
  end

  always_comb begin
    ov_hit = CONVERT_EN &&
             ((SOFTSTART_DONE && {1'b0, VOUT_SENSE} > threshold) ||
              (FIXED_OV_SELECT && trip_s));
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ov_flag <= 1'b0;
    end else if (ov_hit) begin
      ov_flag <= 1'b1;
    end else if (CLEAR_FAULTS) begin
      ov_flag <= 1'b0;
    end
  end

  // An ignored fault stays pending until cleared or acted upon.
  // Pending earlier fault.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pending <= 1'b0;
    end else if (ov_hit && !act_fault) begin
      pending <= 1'b1;
    end else if (CLEAR_FAULTS || act_fault) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      STATUS_BYTE_OV <= 1'b0;
      STATUS_WORD_VOUT <= 1'b0;
      STATUS_VOUT_OV <= 1'b0;
      INVALID_DATA <= 1'b0;
      SMBALERT_OUT <= 1'b0;
      SMBALERT_OE <= 1'b0;
    end else begin
      STATUS_BYTE_OV <= ov_flag;
      STATUS_WORD_VOUT <= ov_flag;
      STATUS_VOUT_OV <= ov_flag;
      INVALID_DATA <= invalid_flag;
      SMBALERT_OUT <= 1'b0;
      SMBALERT_OE <= ov_flag || invalid_flag;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_d <= 1'b0;
    end else begin
      en_d <= en_s;
    end
  end

  assign en_rise = en_s && !en_d;
  assign retry_done = retry_cnt == RETRY_CYCLES - 23'h000001;
  assign act_fault = state == covr_pkg::COVR_ST_RUN && pending &&
                     resp_en_n;

  always_comb begin
    next_state = state;
    case (state)
      covr_pkg::COVR_ST_RUN: begin
        if (act_fault) begin
          if (retry_bit) begin
            next_state = covr_pkg::COVR_ST_RETRY;
          end else begin
            next_state = covr_pkg::COVR_ST_LATCHED;
          end
        end
      end
      covr_pkg::COVR_ST_LATCHED: begin
        if (en_rise) begin
          next_state = covr_pkg::COVR_ST_RUN;
        end
      end
      covr_pkg::COVR_ST_RETRY: begin
        if (retry_done) begin
          next_state = covr_pkg::COVR_ST_RUN;
        end
      end
      default: begin
        next_state = covr_pkg::COVR_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= covr_pkg::COVR_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      retry_cnt <= 23'h000000;
    end else if (state == covr_pkg::COVR_ST_RETRY && !retry_done) begin
      retry_cnt <= retry_cnt + 23'h000001;
    end else begin
      retry_cnt <= 23'h000000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CONVERT_EN <= 1'b0;
      RESTART <= 1'b0;
    end else begin
      CONVERT_EN <= next_state == covr_pkg::COVR_ST_RUN && en_s;
      RESTART <= state != covr_pkg::COVR_ST_RUN &&
                 next_state == covr_pkg::COVR_ST_RUN;
    end
  end

endmodule

// File: sim/covr_host.sv
/*
  Host model that issues register commands one strobe at a time.
  Assumes SYS_CLK is the block clock and a read answers one cycle later.
*/
`timescale 1ns/1ps
module covr_host (
  input wire logic SYS_CLK, // Clock.
  input wire logic [15:0] CMD_RDATA, // Read data.
  input wire logic CMD_RVALID, // Read data valid.
  output logic CMD_VALID, // Access strobe.
  output logic CMD_WRITE, // Write when high.
  output logic [7:0] CMD_CODE, // Command code.
  output logic [15:0] CMD_WDATA // Write data.
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_WRITE = 1'b0;
    CMD_CODE = 8'h00;
    CMD_WDATA = 16'h0000;
  end
  task automatic access(input logic w, input logic [7:0] c,
      input logic [15:0] d);
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b1;
    CMD_WRITE <= w;
    CMD_CODE <= c;
    CMD_WDATA <= d;
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
    CMD_WRITE <= ~w;
    CMD_CODE <= ~c;
    CMD_WDATA <= ~d;
  endtask
  // A missing valid pulse returns unknown data so the compare fails.
  task automatic read(input logic [7:0] c, output logic [15:0] d);
    access(1'b0, c, 16'h0000);
    @(posedge SYS_CLK);
    d = CMD_RVALID ? CMD_RDATA : 16'hxxxx;
  endtask
endmodule

// File: sim/covr_chk.sv
/*
  Assertions on the ports of the fault register block.
  Assumes it is bound to covr_fault_regs.
*/
`timescale 1ns/1ps
module covr_chk (
  input wire logic SYS_CLK, // Clock.
  input wire logic ARST_N, // Reset, active low.
  input wire logic CMD_VALID, // Strobe.
  input wire logic CMD_WRITE, // Write.
  input wire logic [7:0] CMD_CODE, // Code.
  input wire logic [15:0] CMD_WDATA, // Write data.
  input wire logic [15:0] CMD_RDATA, // Read data.
  input wire logic NVM_RESTORE, // Restore.
  input wire logic CLEAR_FAULTS, // Clear.
  input wire logic INVALID_DATA, // Invalid flag.
  input wire logic SOFTSTART_DONE, // Ramp done.
  input wire logic FIXED_OV_SELECT, // Fixed select.
  input wire logic CONVERT_EN, // Converting.
  input wire logic RESTART, // Restart pulse.
  input wire logic STORE_RESP_EN_N, // Enable image.
  input wire logic STATUS_BYTE_OV, // Flag.
  input wire logic STATUS_WORD_VOUT, // Flag.
  input wire logic STATUS_VOUT_OV, // Flag.
  input wire logic SMBALERT_OUT, // Alert level.
  input wire logic SMBALERT_OE // Alert enable.
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  wire rd = CMD_VALID && !CMD_WRITE;
  wire bad = CMD_VALID && CMD_WRITE && CMD_CODE == 8'h41 && !NVM_RESTORE
    && !CLEAR_FAULTS && CMD_WDATA[5:3] != 3'h0 && CMD_WDATA[5:3] != 3'h7;
  ofs_exp_a:
    assert property (rd && CMD_CODE == 8'h39 |=> CMD_RDATA[15:11] == 5'h1e)
    else $error("offset exponent wrong");
  ofs_sign_a:
    assert property (rd && CMD_CODE == 8'h39 |=>
      CMD_RDATA[10:4] == {7{CMD_RDATA[3]}}) else $error("sign not extended");
  lim_upper_a:
    assert property (rd && CMD_CODE == 8'h40 |=> CMD_RDATA[15:11] == 5'h00)
    else $error("limit upper bits set");
  resp_zero_a:
    assert property (rd && CMD_CODE == 8'h41 |=> CMD_RDATA[15:8] == 8'h00
      && !CMD_RDATA[6]) else $error("response zero bits set");
  delay_mirror_a:
    assert property (rd && CMD_CODE == 8'h41 |=> CMD_RDATA[2:0] ==
      CMD_RDATA[5:3] && CMD_RDATA[3] == CMD_RDATA[5]) else $error("delay");
  retry_reject_a:
    assert property (bad |-> ##2 INVALID_DATA) else $error("bad retry kept");
  flags_same_a:
    assert property (STATUS_BYTE_OV == STATUS_WORD_VOUT &&
      STATUS_WORD_VOUT == STATUS_VOUT_OV) else $error("flags differ");
  alert_src_a:
    assert property (SMBALERT_OE == (STATUS_BYTE_OV || INVALID_DATA) &&
      !SMBALERT_OUT) else $error("alert wrong");
  ramp_gate_a:
    assert property ($rose(STATUS_VOUT_OV) |-> $past(SOFTSTART_DONE, 2) ||
      $past(FIXED_OV_SELECT, 2)) else $error("fault during ramp");
  shut_down_a:
    assert property ($rose(STATUS_VOUT_OV) && STORE_RESP_EN_N |->
      !CONVERT_EN) else $error("output not disabled");
  cover property (bad);
  cover property (RESTART);
  cover property ($fell(CONVERT_EN));
endmodule
bind covr_fault_regs covr_chk covr_chk_i (.*);

// File: sim/testbench.sv
/*
  Self-checking bench for the fault register block.
  Assumes covr_host issues commands and covr_chk is bound to the block.
*/
`timescale 1ns/1ps
module testbench;
  localparam int RC = 20;
  logic SYS_CLK, CMD_VALID, CMD_WRITE, CMD_RVALID, INVALID_DATA;
  logic STORE_RESP_EN_N, STORE_RETRY, CONVERT_EN, RESTART, STATUS_BYTE_OV;
  logic STATUS_WORD_VOUT, STATUS_VOUT_OV, SMBALERT_OUT, SMBALERT_OE;
  logic ARST_N = 1'b0, CLEAR_FAULTS = 1'b0, NVM_RESTORE = 1'b0;
  logic NVM_RESP_EN_N = 1'b1, NVM_RETRY = 1'b0, SOFTSTART_DONE = 1'b0;
  logic FIXED_OV_SELECT = 1'b0, FIXED_OV_TRIP = 1'b0, EN_PIN = 1'b0;
  logic [7:0] CMD_CODE;
  logic [3:0] STORE_MANT, NVM_MANT = 4'h0;
  logic [10:0] STORE_LIMIT, NVM_LIMIT = 11'h000;
  logic [15:0] CMD_WDATA, CMD_RDATA, READ_IOUT, rv;
  logic [15:0] IOUT_MEAS = 16'h0005, VOUT_CMD = 16'h03e8;
  logic [15:0] VOUT_SENSE = 16'h0000;
  logic [3:0] mt [4] = '{4'h7, 4'h8, 4'hf, 4'h0};
  logic [15:0] it [4] = '{16'h000c, 16'h0000, 16'h0004, 16'h0005};
  logic [10:0] lc [4] = '{11'h000, 11'h248, 11'h25c, 11'h29a};
  logic [15:0] th [4] = '{16'h0460, 16'h0488, 16'h04b0, 16'h05dc};
  int bad_count = 0;
  int tests_run = 0;
  int n;
  covr_fault_regs #(.RETRY_CYCLES(23'(RC))) covr_fault_regs_i (.*);
  covr_host covr_host_i (.*);
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    covr_host_i.read(c, rv);
    chk(rv, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    covr_host_i.access(1'b1, c, d);
  endtask
  task automatic clr;
    CLEAR_FAULTS <= 1'b1;
    tick(1);
    CLEAR_FAULTS <= 1'b0;
    tick(3);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    bad_count++;
    stop_test();
  end
  initial begin
    tick(8);
    ARST_N <= 1'b1;
    EN_PIN <= 1'b1;
    SOFTSTART_DONE <= 1'b1;
    tick(5);
    chb(CONVERT_EN, 1'b1);
    rc(8'h39, 16'hf000);
    rc(8'h40, 16'h0000);
    rc(8'h41, 16'h0080);
    rc(8'h55, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h39, {12'hfff, mt[i]});
      rc(8'h39, {5'h1e, {7{mt[i][3]}}, mt[i]});
      tick(2);
      chk(READ_IOUT, it[i]);
    end
    wr(8'h40, 16'hffff);
    rc(8'h40, 16'h07ff);
    wr(8'h41, 16'hff7f);
    rc(8'h41, 16'h003f);
    chb(STORE_RETRY, 1'b1);
    wr(8'h41, 16'h00d0);
    rc(8'h41, 16'h003f);
    chb(SMBALERT_OE, 1'b1);
    clr();
    chb(INVALID_DATA, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, {5'h00, lc[i]});
      VOUT_SENSE <= th[i];
      tick(5);
      chb(STATUS_VOUT_OV, 1'b0);
      VOUT_SENSE <= th[i] + 16'h0001;
      tick(5);
      chb(STATUS_VOUT_OV, 1'b1);
      chb(CONVERT_EN, 1'b1);
      VOUT_SENSE <= 16'h0000;
      clr();
    end
    SOFTSTART_DONE <= 1'b0;
    VOUT_SENSE <= 16'h0fff;
    tick(5);
    chb(STATUS_VOUT_OV, 1'b0);
    SOFTSTART_DONE <= 1'b1;
    tick(5);
    chb(STATUS_VOUT_OV, 1'b1);
    chb(STATUS_BYTE_OV & STATUS_WORD_VOUT, 1'b1);
    VOUT_SENSE <= 16'h0000;
    wr(8'h41, 16'h0080);
    tick(4);
    chb(CONVERT_EN, 1'b0);
    tick(RC * 2);
    chb(CONVERT_EN, 1'b0);
    chb(STORE_RETRY, 1'b0);
    EN_PIN <= 1'b0;
    tick(4);
    EN_PIN <= 1'b1;
    tick(6);
    chb(CONVERT_EN, 1'b1);
    clr();
    wr(8'h41, 16'h00b8);
    FIXED_OV_SELECT <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      FIXED_OV_TRIP <= 1'b1;
      tick(6);
      FIXED_OV_TRIP <= 1'b0;
      chb(CONVERT_EN, 1'b0);
      n = 0;
      while (!RESTART && n < 100) begin
        tick(1);
        n++;
      end
      chb(n >= RC - 3 && n <= RC + 1, 1'b1);
      tick(3);
      chb(CONVERT_EN, 1'b1);
    end
    FIXED_OV_SELECT <= 1'b0;
    clr();
    NVM_MANT <= 4'h9;
    NVM_LIMIT <= 11'h123;
    NVM_RESP_EN_N <= 1'b0;
    NVM_RETRY <= 1'b1;
    NVM_RESTORE <= 1'b1;
    tick(1);
    NVM_RESTORE <= 1'b0;
    rc(8'h41, 16'h003f);
    rc(8'h39, 16'hf7f9);
    rc(8'h40, 16'h0123);
    chk({12'h000, STORE_MANT}, 16'h0009);
    chk({5'h00, STORE_LIMIT}, 16'h0123);
    stop_test();
  end
endmodule
